// File: rtl/ebtc_consts.svh
`ifndef EBTC_CONSTS_SVH
`define EBTC_CONSTS_SVH

// counter width, prescale select width, counter limit and reset values
`define EBTC_CNT_W      8
`define EBTC_PS_W       3
`define EBTC_CNT_MAX    8'hff
`define EBTC_CNT_RST    8'h00
`define EBTC_PRE_RST    8'h00
// increment hold-off after a software write, in instruction cycles
`define EBTC_HOLD_CYC   2'h2
`define EBTC_HOLD_RST   2'h0

`endif

// File: rtl/ebtc_pkg.sv
package ebtc_pkg;
  `include "ebtc_consts.svh"

  typedef logic [`EBTC_CNT_W-1:0] ebtc_cnt_t;
  typedef logic [`EBTC_PS_W-1:0]  ebtc_ps_t;

  typedef enum logic [1:0] {
    EBTC_HOLD_IDLE = 2'b00,
    EBTC_HOLD_ONE  = 2'b01,
    EBTC_HOLD_TWO  = 2'b10
  } ebtc_hold_e;
endpackage

// File: rtl/ebtc_prescaler.sv
`timescale 1ns/1ps
`include "ebtc_consts.svh"

// ---------------------------------------------------------------
// prescaler: divides count ticks by 2^(ps+1)
// ---------------------------------------------------------------
module ebtc_prescaler
  import ebtc_pkg::*;
(
  // clock and reset
  input  wire logic     i_clk,
  input  wire logic     i_resetn,
  // control
  input  wire logic     i_clear,
  input  wire logic     i_tick,
  input  wire ebtc_ps_t i_ps,
  // output
  output logic          o_tick
);

  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic [7:0] mask;

  // dedicated prescaler, no sharing with any watchdog
  always_comb begin
    pre_d  = pre_q + 8'h01;
    mask   = 8'((9'h002 << i_ps) - 9'h001);
    o_tick = i_tick && ((pre_q & mask) == mask);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn || i_clear) begin
      pre_q <= `EBTC_PRE_RST;
    end else if (i_tick) begin
      pre_q <= pre_d;
    end
  end

endmodule

// File: rtl/ebtc_timer.sv
`timescale 1ns/1ps
`include "ebtc_consts.svh"

// Behaviour
// - one 8-bit register, timer or counter
// - bypassed prescaler, internal source: count every cycle
// - source select set: count external input edges
// - edge select picks rising or falling edge
// - write blocks counting two following cycles
// - separate 8-bit prescaler before the counter
// - overflow offered as gate for 16-bit timer
module ebtc_timer
  import ebtc_pkg::*;
(
  // clock and reset
  input  wire logic     i_clk,
  input  wire logic     i_resetn,
  // configuration
  input  wire logic     i_count_source_select,
  input  wire logic     i_source_edge_select,
  input  wire logic     i_prescaler_bypass,
  input  wire ebtc_ps_t i_prescale_sel,
  // software write of the count register
  input  wire logic     i_wr_en,
  input  wire ebtc_cnt_t i_wr_data,
  // overflow flag clear
  input  wire logic     i_flag_clear,
  // external pin
  input  wire logic     i_external_count_input,
  // status
  output ebtc_cnt_t     o_count_register,
  output logic          o_overflow_flag,
  output logic          o_overflow_gate
);

  ebtc_cnt_t  cnt_q;
  logic       ext_q;
  logic       flag_q;
  logic       gate_q;
  ebtc_hold_e hold_q;
  logic       ext_edge;
  logic       src_tick;
  logic       pre_tick;
  logic       inc;
  logic       roll;

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= i_external_count_input;
    end
  end

  // edge select 0 = rising, 1 = falling
  // limitation: a pin level shorter than one clock is missed unless it spans a rising clock edge
  always_comb begin
    ext_edge = i_source_edge_select ? (ext_q && !i_external_count_input)
                                    : (!ext_q && i_external_count_input);
    src_tick = i_count_source_select ? ext_edge : 1'b1;
  end

  // writes clear the prescaler so a load always starts a whole prescaler period
  ebtc_prescaler u_pre (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clear  (i_wr_en),
    .i_tick   (src_tick),
    .i_ps     (i_prescale_sel),
    .o_tick   (pre_tick)
  );

  // ---------------------------------------------------------------
  // write hold-off
  // ---------------------------------------------------------------
  // a reload during hold-off restarts the two-cycle window
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      hold_q <= EBTC_HOLD_IDLE;
    end else if (i_wr_en) begin
      hold_q <= EBTC_HOLD_TWO;
    end else begin
      unique case (hold_q)
        EBTC_HOLD_TWO:  hold_q <= EBTC_HOLD_ONE;
        EBTC_HOLD_ONE:  hold_q <= EBTC_HOLD_IDLE;
        EBTC_HOLD_IDLE: hold_q <= EBTC_HOLD_IDLE;
        default:        hold_q <= EBTC_HOLD_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_comb begin
    inc  = (i_prescaler_bypass ? src_tick : pre_tick)
           && !i_wr_en && (hold_q == EBTC_HOLD_IDLE);
    roll = inc && (cnt_q == `EBTC_CNT_MAX);
  end

  // software picks the loaded value to absorb the hold-off
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_q <= `EBTC_CNT_RST;
    end else if (i_wr_en) begin
      cnt_q <= i_wr_data;
    end else if (inc) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      flag_q <= 1'b0;
    end else if (roll) begin
      flag_q <= 1'b1;
    end else if (i_flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  // one-cycle overflow pulse for the 16-bit timer's gate mux
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= roll;
    end
  end

  assign o_count_register = cnt_q;
  assign o_overflow_flag  = flag_q;
  assign o_overflow_gate  = gate_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // ---------------------------------------------------------------
  // count path and edge select
  // ---------------------------------------------------------------
  timer_step_a: assert property (i_prescaler_bypass && !i_count_source_select
    && !i_wr_en && hold_q == EBTC_HOLD_IDLE |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("timer did not advance");
  timer_pre_a: assert property (!i_prescaler_bypass && !i_count_source_select
    && pre_tick && !i_wr_en && hold_q == EBTC_HOLD_IDLE
    |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("prescaled timer missed tick");
  pre_div_a: assert property (!i_prescaler_bypass && !src_tick
    |=> cnt_q == $past(cnt_q) || $past(i_wr_en))
    else $error("prescaled count moved without tick");
  ext_step_a: assert property (i_prescaler_bypass && i_count_source_select
    && !i_wr_en && hold_q == EBTC_HOLD_IDLE && ext_edge
    |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter missed edge");
  ext_still_a: assert property (i_count_source_select && !ext_edge && !i_wr_en
    |=> cnt_q == $past(cnt_q))
    else $error("counter moved without edge");
  fall_step_a: assert property (i_prescaler_bypass && i_count_source_select
    && i_source_edge_select && ext_q && !i_external_count_input
    && !i_wr_en && hold_q == EBTC_HOLD_IDLE |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter missed falling edge");
  rise_only_a: assert property (i_count_source_select && !i_source_edge_select
    && ext_q && !i_external_count_input && !i_wr_en |=> cnt_q == $past(cnt_q))
    else $error("falling edge counted in rising mode");
  fall_only_a: assert property (i_count_source_select && i_source_edge_select
    && !ext_q && i_external_count_input && !i_wr_en |=> cnt_q == $past(cnt_q))
    else $error("rising edge counted in falling mode");

  // ---------------------------------------------------------------
  // write hold-off
  // ---------------------------------------------------------------
  write_hold_a: assert property (i_wr_en |=> cnt_q == $past(i_wr_data)
    ##1 (cnt_q == $past(cnt_q) || $past(i_wr_en)))
    else $error("count moved during hold-off");
  hold_arm_a: assert property (i_wr_en |=> hold_q == EBTC_HOLD_TWO)
    else $error("write did not start hold-off");
  hold_block_a: assert property (hold_q != EBTC_HOLD_IDLE && !i_wr_en
    |=> cnt_q == $past(cnt_q))
    else $error("count moved in hold-off window");
  hold_end_a: assert property (hold_q == EBTC_HOLD_ONE && !i_wr_en
    |=> hold_q == EBTC_HOLD_IDLE)
    else $error("hold-off lasted too long");
  write_load_a: assert property (i_wr_en ##1 !i_wr_en [*3]
    |-> cnt_q == $past(i_wr_data, 3))
    else $error("count wrong after hold-off");

  // ---------------------------------------------------------------
  // overflow flag and gate
  // ---------------------------------------------------------------
  flag_set_a: assert property (roll |=> flag_q && cnt_q == `EBTC_CNT_RST)
    else $error("rollover missed flag");
  flag_keep_a: assert property (flag_q && !i_flag_clear |=> flag_q)
    else $error("flag dropped by itself");
  flag_cause_a: assert property ($rose(flag_q) |-> $past(roll))
    else $error("flag set without rollover");
  flag_clear_a: assert property (flag_q && i_flag_clear && !roll |=> !flag_q)
    else $error("flag clear ignored");
  gate_pulse_a: assert property (roll |=> gate_q ##1 !gate_q || $past(roll))
    else $error("gate pulse wrong");
  gate_cause_a: assert property (gate_q |-> $past(roll))
    else $error("gate pulse without rollover");
  gate_width_a: assert property (gate_q |=> !gate_q)
    else $error("gate pulse too long");

  // ---------------------------------------------------------------
  // coverage
  // ---------------------------------------------------------------
  roll_c:     cover property (roll);
  ext_c:      cover property (i_count_source_select && inc);
  hold_c:     cover property (i_wr_en ##1 hold_q == EBTC_HOLD_TWO ##1 hold_q == EBTC_HOLD_ONE);
  flag_clr_c: cover property (flag_q ##1 !flag_q);
  pre_c:      cover property (!i_prescaler_bypass && inc);

endmodule

// File: dv/ebtc_pulse_src.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// external pulse source
// ---------------------------------------------------------------
module ebtc_pulse_src (
  // clock and request
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [3:0] i_n,
  // count pin
  output logic            o_pin
);
  logic [4:0] left_q = 5'h00;
  logic [1:0] div_q  = 2'h0;
  // pulled low between bursts; each level lasts four cycles
  always_ff @(posedge i_clk) begin
    div_q <= div_q + 2'h1;
    if (i_go) begin
      left_q <= {i_n, 1'b0};
    end else if (left_q != 5'h00 && div_q == 2'h0) begin
      left_q <= left_q - 5'h01;
    end
  end
  assign o_pin = left_q[0];
endmodule

// File: dv/eight_bit_timer_counter_test.sv
`timescale 1ns/1ps
module eight_bit_timer_counter_test
  import ebtc_pkg::*;
;
  logic      clk = 1'b0, resetn = 1'b0, src = 1'b0, fall = 1'b0, byp = 1'b1;
  logic      wr = 1'b0, clr = 1'b0, go = 1'b0, flag, gate, pin;
  ebtc_ps_t  ps = 3'h0;
  ebtc_cnt_t wd = 8'h00, cnt;
  int        num_errors = 0, total_checks = 0;

  ebtc_timer i_dut (.i_clk(clk), .i_resetn(resetn), .i_count_source_select(src),
    .i_source_edge_select(fall), .i_prescaler_bypass(byp), .i_prescale_sel(ps),
    .i_wr_en(wr), .i_wr_data(wd), .i_flag_clear(clr), .i_external_count_input(pin),
    .o_count_register(cnt), .o_overflow_flag(flag), .o_overflow_gate(gate));
  ebtc_pulse_src i_src (.i_clk(clk), .i_go(go), .i_n(4'h3), .o_pin(pin));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic cfg(input logic s, f, b, input ebtc_ps_t p);
    @(posedge clk);
    src <= s; fall <= f; byp <= b; ps <= p;
  endtask
  task automatic load(input ebtc_cnt_t v);
    @(posedge clk); wr <= 1'b1; wd <= v;
    @(posedge clk); wr <= 1'b0;
    #1;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_holdoff;
    cfg(1'b0, 1'b0, 1'b1, 3'h0); load(8'h40);
    tick(2); check(cnt, 8'h40);
    tick(1); check(cnt, 8'h41);
    tick(5); check(cnt, 8'h46);
    load(8'h3e); tick(4); check(cnt, 8'h40);
    $display("hold-off test done");
  endtask
  task automatic t_roll;
    cfg(1'b0, 1'b0, 1'b1, 3'h0); load(8'hfe);
    tick(4); check(cnt, 8'h00);
    check({6'h00, gate, flag}, 8'h03);
    tick(1); check({6'h00, gate, flag}, 8'h01);
    @(posedge clk); clr <= 1'b1;
    @(posedge clk); clr <= 1'b0;
    #1; check({7'h00, flag}, 8'h00);
    $display("rollover test done");
  endtask
  task automatic t_ext(input logic f, input logic b);
    cfg(1'b1, f, b, 3'h0); load(8'h00);
    tick(3);
    @(posedge clk); go <= 1'b1;
    @(posedge clk); go <= 1'b0;
    for (int i = 0; i < 8 && pin !== 1'b1; i++) begin
      @(posedge clk); #1;
    end
    tick(2); check(cnt, {7'h00, ~f & b});
    tick(40); check(cnt, b ? 8'h03 : 8'h01);
    $display("external edge test done");
  endtask
  task automatic t_pre;
    ebtc_cnt_t c;
    for (int s = 0; s < 8; s++) begin
      cfg(1'b0, 1'b0, 1'b0, s[2:0]); load(8'h00);
      tick(2); c = cnt;
      // 256 cycles is a whole number of periods for every ratio
      tick(256); check(cnt, c + 8'(9'h100 >> (s + 1)));
    end
    $display("prescaler test done");
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_holdoff; t_roll; t_ext(1'b0, 1'b1); t_ext(1'b1, 1'b1); t_ext(1'b0, 1'b0); t_pre;
    finish_test;
  end
  // tests need about 2500 cycles; allow four times that
  initial begin
    #1000000;
    num_errors++;
    finish_test;
  end
endmodule
